/* core/sgc_port.sv */
// Purpose: serial gain programming port with sleep and transmit controls
// Assumes: gain word crosses by toggle handshake into clock_in domain
// Notes: outputs are registered in the clock_in domain
//
// Contract
// - rising load enable applies the shifted word and stops shifting.
// - falling load enable freezes applied gain and opens the shifter.
// - the gain word is eight bits, most significant first.
// - each serial clock rise captures a bit in the master stage.
// - each serial clock fall moves the master bit into the slave stage.
// - sleep low powers down with output in high impedance.
// - transmit-on low disables transmission, high enables it.
// - only the six low bits of the word are kept.
// - codes one to sixty are valid one-decibel steps.
// - codes sixty-one to sixty-three apply code sixty.
`timescale 1ns/1ps
module sgc_port
    import sgc_pkg::*;
(
    input wire logic clock_in,          // system clock
    input wire logic srst_in,           // sync reset, active high
    input wire logic sclk_in,           // serial clock from host
    input wire logic load_enable_n_in,  // active-low load enable
    input wire logic serial_gain_in,    // serial gain data
    input wire logic sleep_n_in,        // active-low sleep
    input wire logic transmit_on_in,    // transmit enable
    output logic [5:0] gain_code_out,   // applied gain code
    output logic powered_out,           // core powered up
    output logic output_en_out,         // output stage driving
    output logic transmit_out           // forward transmission on
);
    import sgc_pkg::*;

    sgc_link_if link ();

    sgc_shift u_shift (
        .sclk_in(sclk_in),
        .load_enable_n_in(load_enable_n_in),
        .serial_gain_in(serial_gain_in),
        .link(link.link)
    );

    // ****************************************
    // synchronisers
    // ****************************************
    logic [2:0] s1;
    logic [2:0] s2;
    logic tog_prev;
    logic [2:0] next_s1;

    always_comb begin
        next_s1 = {link.toggle, sleep_n_in, transmit_on_in};
    end

    always_ff @(posedge clock_in) begin
        s1 <= next_s1;
        s2 <= s1;
    end

    function automatic logic [5:0] map_code(input logic [7:0] w);
        logic [5:0] c;
        c = w[SGC_CODE_W-1:0];
        // codes up to max pass through
        map_code = (c > SGC_CODE_MAX) ? SGC_CODE_MAX : c;
    endfunction : map_code

    // ****************************************
    // applied state
    // ****************************************
    logic [5:0] gain;
    logic [5:0] next_gain;
    sgc_pwr_t pwr;
    sgc_pwr_t next_pwr;
    logic next_tog_prev;

    always_comb begin
        next_tog_prev = s2[2];
        next_gain = gain;
        if (s2[2] != tog_prev) begin
            next_gain = map_code(link.word);
        end
        unique case ({s2[1], s2[0]})
            2'b00, 2'b01: next_pwr = SGC_OFF;
            2'b10: next_pwr = SGC_IDLE;
            2'b11: next_pwr = SGC_XMIT;
            default: next_pwr = SGC_OFF;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            gain <= SGC_CODE_RESET;
            pwr <= SGC_OFF;
            // track the toggle so a word loaded before reset is not applied again
            tog_prev <= s2[2];
        end else begin
            gain <= next_gain;
            pwr <= next_pwr;
            tog_prev <= next_tog_prev;
        end
    end

    assign gain_code_out = gain;
    assign powered_out = (pwr != SGC_OFF);
    assign output_en_out = (pwr != SGC_OFF);
    assign transmit_out = (pwr == SGC_XMIT);

    // ****************************************
    // checks
    // ****************************************
    a_gain_clamped: assert property (
        @(posedge clock_in) disable iff (srst_in) gain <= SGC_CODE_MAX)
        else $error("gain code above max");
    a_sleep_off: assert property (
        @(posedge clock_in) disable iff (srst_in) !s2[1] |=> !output_en_out)
        else $error("output on during sleep");
    a_tx_gate: assert property (
        @(posedge clock_in) disable iff (srst_in) (s2[1] && !s2[0]) |=> !transmit_out)
        else $error("transmit while disabled");
    a_gain_apply: assert property (
        @(posedge clock_in) disable iff (srst_in)
        (s2[2] != tog_prev) |=> gain == map_code($past(link.word)))
        else $error("gain not applied");
    a_gain_hold: assert property (
        @(posedge clock_in) disable iff (srst_in)
        (s2[2] == tog_prev) |=> $stable(gain))
        else $error("gain moved without load");
    a_tx_follow: assert property (
        @(posedge clock_in) disable iff (srst_in) (s2[1] && s2[0]) |=> transmit_out)
        else $error("transmit not enabled");
    a_power_on: assert property (
        @(posedge clock_in) disable iff (srst_in) s2[1] |=> (powered_out && output_en_out))
        else $error("not powered while awake");
endmodule : sgc_port

/* core/sgc_pkg.sv */
// Purpose: shared constants and types for the serial gain control port
// Assumes: one system clock plus the serial link clock from the host
// Notes: gain code limits live here only; sgc_port and sgc_link_if repeat the word widths as literals
package sgc_pkg;
    localparam int SGC_WORD_W = 8;
    localparam int SGC_CODE_W = 6;
    localparam logic [5:0] SGC_CODE_MAX = 6'h3C;
    localparam logic [5:0] SGC_CODE_RESET = 6'h00;
    localparam logic [7:0] SGC_WORD_RESET = 8'h00;
    localparam int SGC_SYNC_STAGES = 2;
    typedef enum logic [1:0] {
        SGC_OFF = 2'b00,
        SGC_IDLE = 2'b01,
        SGC_XMIT = 2'b11
    } sgc_pwr_t;
endpackage : sgc_pkg

/* core/sgc_link_if.sv */
// Purpose: carries the gain word and its update toggle across the clock boundary
// Assumes: word is stable whenever the toggle changes
// Notes: the toggle is an event, the word is held data
`timescale 1ns/1ps
interface sgc_link_if;
    logic [7:0] word;
    logic toggle;
    modport link (output word, output toggle);
    modport core (input word, input toggle);
endinterface : sgc_link_if

/* core/sgc_shift.sv */
// Purpose: master-slave serial shift register on the serial clock
// Assumes: host keeps data valid at the capturing edge
// Notes: no reset exists on this domain, matching the part
`timescale 1ns/1ps
module sgc_shift
    import sgc_pkg::*;
(
    input wire logic sclk_in,           // serial clock from host
    input wire logic load_enable_n_in,  // active-low load enable
    input wire logic serial_gain_in,    // serial data, msb first
    sgc_link_if.link link               // word and update toggle out
);
    // ****************************************
    // shift and transfer
    // ****************************************
    logic master;
    logic next_master;
    logic [SGC_WORD_W-1:0] slave;
    logic [SGC_WORD_W-1:0] next_slave;
    logic [SGC_WORD_W-1:0] held;
    // the serial domain has no reset, so the event toggle starts from a known level
    logic toggle = 1'b0;
    logic en_q;
    logic next_en_q;

    always_comb begin
        next_master = load_enable_n_in ? master : serial_gain_in;
        next_en_q = ~load_enable_n_in;
    end

    always_ff @(posedge sclk_in) begin
        master <= next_master;
        en_q <= next_en_q;
    end

    always_comb begin
        // msb enters first and ends at the top
        next_slave = en_q ? {slave[SGC_WORD_W-2:0], master} : slave;
    end

    always_ff @(negedge sclk_in) begin
        slave <= next_slave;
    end

    always_ff @(posedge load_enable_n_in) begin
        held <= slave;
        toggle <= ~toggle;
    end

    assign link.word = held;
    assign link.toggle = toggle;
endmodule : sgc_shift

/* bench/sgc_host.sv */
// Purpose: host model driving the serial gain lines
// Assumes: serial clock runs only inside a frame, 6 ns period
// Notes: data shows the inverse of its last bit once released
`timescale 1ns/1ps
module sgc_host (
    output logic sclk_out = 1'b0,          // serial clock
    output logic load_enable_n_out = 1'b1, // active-low load enable, no edge at start
    output logic data_out = 1'b0           // serial data
);
    task automatic send(input logic [7:0] w, input bit en);
        load_enable_n_out = ~en;
        #3;
        for (int i = 7; i >= 0; i--) begin
            data_out = w[i];
            #3 sclk_out = 1'b1;
            #3 sclk_out = 1'b0;
        end
        data_out = ~w[0];
        #3 load_enable_n_out = 1'b1;
    endtask : send
endmodule : sgc_host

/* bench/tb_sgc_port.sv */
// Purpose: self-checking bench for the serial gain port
// Assumes: gain settles within eight system clocks of a load
// Notes: power outputs follow their inputs after three clocks
`timescale 1ns/1ps
module tb_sgc_port;
    import sgc_pkg::*;
    logic clock_in = 0, srst_in = 1, sleep_n = 0, tx_on = 0;
    logic sclk, len_n, sdat, pwr, oen, txo;
    logic [5:0] gain;
    int num_errors = 0, n_tests = 0;
    logic [7:0] words [7] = '{8'h01, 8'h3C, 8'h3D, 8'h3F, 8'h4B, 8'hFE, 8'h00};
    logic [5:0] codes [7] = '{6'h01, 6'h3C, 6'h3C, 6'h3C, 6'h0B, 6'h3C, 6'h00};
    sgc_host h (.sclk_out(sclk), .load_enable_n_out(len_n), .data_out(sdat));
    sgc_port dut (.clock_in(clock_in), .srst_in(srst_in), .sclk_in(sclk),
        .load_enable_n_in(len_n), .serial_gain_in(sdat), .sleep_n_in(sleep_n),
        .transmit_on_in(tx_on), .gain_code_out(gain), .powered_out(pwr),
        .output_en_out(oen), .transmit_out(txo));
    initial begin
        forever #5 clock_in = ~clock_in;
    end
    task automatic chk_gain(input logic [5:0] exp);
        n_tests++;
        if (gain !== exp) begin
            num_errors++;
            $display("ERROR t=%0t gain got %h exp %h", $time, gain, exp);
        end
    endtask : chk_gain
    task automatic chk_pwr(input logic [2:0] exp);
        n_tests++;
        if ({pwr, oen, txo} !== exp) begin
            num_errors++;
            $display("ERROR t=%0t power got %h exp %h", $time, {pwr, oen, txo}, exp);
        end
    endtask : chk_pwr
    task automatic load(input logic [7:0] w, input bit en);
        @(negedge clock_in);
        h.send(w, en);
        repeat (8) @(negedge clock_in);
    endtask : load
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish
    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        repeat (4) @(negedge clock_in);
        chk_gain(6'h00);
        srst_in = 0;
        for (int i = 0; i < 7; i++) begin
            load(words[i], 1'b1);
            chk_gain(codes[i]);
        end
        $display("gain table done");
        load(8'h25, 1'b1);
        load(8'h3C, 1'b0);
        chk_gain(6'h25);
        load(8'h07, 1'b1);
        chk_gain(6'h07);
        $display("refused bits done");
        for (int i = 0; i < 4; i++) begin
            {sleep_n, tx_on} = i[1:0];
            repeat (5) @(negedge clock_in);
            chk_pwr(i[1] ? {2'b11, i[0]} : 3'b000);
        end
        $display("power done");
        srst_in = 1;
        repeat (4) @(negedge clock_in);
        srst_in = 0;
        chk_gain(6'h00);
        repeat (8) @(negedge clock_in);
        chk_gain(6'h00);
        $display("reset done");
        tally_and_finish();
    end
    initial begin
        #20000;
        num_errors++;
        tally_and_finish();
    end
endmodule : tb_sgc_port
